// >>> logic/tcc_pkg.sv
// constants shared by the timer channel capture/compare block
`default_nettype none

package tcc_pkg;

  // structure
  localparam int N_CH = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CW = 16;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_HI = 8'h10;
  localparam logic [7:0] OFF_LO = 8'h20;
  localparam logic [7:0] OFF_SEL = 8'h30;

  // channel control register field positions
  localparam int B_FLAG = 7;
  localparam int B_IE = 6;
  localparam int B_MSB = 5;
  localparam int B_MSA = 4;
  localparam int B_ELSH = 3;
  localparam int B_ELSL = 2;
  localparam int B_TOV = 1;
  localparam int B_MAX = 0;

  // edge select codes
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [N_CH-1:0] SEL_RST = 4'h0;

endpackage

`default_nettype wire

// >>> logic/tcc_capture.sv
// four-channel timer input capture / compare unit with apb registers
//
// How it works
// - edge sets flag; enabled flag raises request
// - pin inputs synchronised, one-clock events captured
// - latched count follows transition by two clocks
// - high byte read blocks capture until low
// - each unlocked selected edge recaptures, flag or not
// - cpu mode: read flag set, write zero
// - dma mode: low byte access clears flag
// - write one ignored; reset clears control
// - select bit routes to interrupt or dma
// - even buffered select disables odd partner
// - mode a: one compare, zero capture
// - edge select: off, rise, fall, both
// - edge select zero releases pin
// - control eight bits, odd bit five zero
// - channel values unreset, software writable storage
// - compare mode: match with counter sets flag
// - channels independent, may share one count
// - per channel edge choice under software
`timescale 1ns/1ps
`default_nettype none

module tcc_capture #(
  parameter bit HAS_DMA = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [tcc_pkg::AW-1:0] i_paddr,
  input wire logic [tcc_pkg::DW-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [tcc_pkg::DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [tcc_pkg::N_CH-1:0] i_channel_pin,
  input wire logic [tcc_pkg::CW-1:0] i_shared_counter_value,
  output logic [tcc_pkg::N_CH-1:0] o_cpu_irq,
  output logic [tcc_pkg::N_CH-1:0] o_dma_req,
  output logic [tcc_pkg::N_CH-1:0] o_pin_connected
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [N_CH-1:0] sync1_q;
  logic [N_CH-1:0] sync2_q;
  logic [N_CH-1:0] prev_q;
  logic [N_CH-1:0] flag_q;
  logic [N_CH-1:0] ie_q;
  logic [N_CH-1:0] msb_q;
  logic [N_CH-1:0] msa_q;
  logic [N_CH-1:0] tov_q;
  logic [N_CH-1:0] max_q;
  logic [1:0] els_q [N_CH];
  logic [CW-1:0] val_q [N_CH];
  logic [N_CH-1:0] lock_q;
  logic [N_CH-1:0] armed_q;
  logic [N_CH-1:0] cmpblk_q;
  logic [N_CH-1:0] match_q;
  logic [N_CH-1:0] sel_q;
  logic [DW-1:0] prdata_q;
  logic [DW-1:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setup;
  logic acc;
  logic mapped;
  logic wr_ok;
  logic rd_ok;
  logic [1:0] chi;
  logic [3:0] grp;

  assign chi = i_paddr[3:2];
  assign grp = i_paddr[7:4];
  assign setup = i_psel & ~i_penable;
  assign acc = i_psel & i_penable;
  // unaligned or unused addresses answer with an error
  assign mapped = (i_paddr[1:0] == 2'h0) &&
                  (grp == OFF_CTRL[7:4] || grp == OFF_HI[7:4] ||
                   grp == OFF_LO[7:4] || i_paddr == OFF_SEL);
  assign wr_ok = acc & i_pwrite & mapped & i_pstrb[0];
  assign rd_ok = acc & ~i_pwrite & mapped;
  // zero wait states: read data is staged in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // per-channel decode and event logic

  logic [N_CH-1:0] hit_ctrl;
  logic [N_CH-1:0] hit_hi;
  logic [N_CH-1:0] hit_lo;
  logic [N_CH-1:0] dis;
  logic [N_CH-1:0] cap_mode;
  logic [N_CH-1:0] cmp_mode;
  logic [N_CH-1:0] dma_mode;
  logic [N_CH-1:0] edge_det;
  logic [N_CH-1:0] rd_hi_pend;
  logic [N_CH-1:0] cap_ev;
  logic [N_CH-1:0] cmp_ev;
  logic [N_CH-1:0] ev;
  logic [N_CH-1:0] lo_acc;
  logic [N_CH-1:0] wr_val;
  logic [7:0] ctrl_rd [N_CH];

  // each channel is its own copy, sharing the counter and, for odd ones, the even partner's buffered bit
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    localparam int M = c - (c % 2);
    localparam bit EVEN = (c % 2 == 0);

    assign hit_ctrl[c] = mapped && grp == OFF_CTRL[7:4] && chi == 2'(c);
    assign hit_hi[c] = mapped && grp == OFF_HI[7:4] && chi == 2'(c);
    assign hit_lo[c] = mapped && grp == OFF_LO[7:4] && chi == 2'(c);
    assign wr_val[c] = wr_ok & (hit_hi[c] | hit_lo[c]);

    // odd channel gives way to its even partner in buffered mode
    assign dis[c] = !EVEN && msb_q[M];
    // mode a only counts while the pair is unbuffered
    assign cap_mode[c] = ~dis[c] & ~msb_q[M] & ~msa_q[c] &
                         (els_q[c] != ELS_OFF);
    assign cmp_mode[c] = ~dis[c] & ~msb_q[M] & msa_q[c];
    assign dma_mode[c] = HAS_DMA & ie_q[c] & sel_q[c];
    assign o_pin_connected[c] = ~dis[c] & (els_q[c] != ELS_OFF);

    // high select bit watches falls, low watches rises
    assign edge_det[c] = (els_q[c][1] & ~sync2_q[c] & prev_q[c]) |
                         (els_q[c][0] & sync2_q[c] & ~prev_q[c]);

    // a high-byte read blocks capture from its setup cycle on,
    // otherwise the staged high byte could be torn
    assign rd_hi_pend[c] = i_psel & ~i_pwrite & hit_hi[c];
    assign cap_ev[c] = cap_mode[c] & edge_det[c] & ~lock_q[c] &
                       ~rd_hi_pend[c];
    // only the first cycle of a match counts, a halted counter
    // would otherwise re-flag forever
    assign cmp_ev[c] = cmp_mode[c] & ~cmpblk_q[c] & ~match_q[c] &
                       (val_q[c] == i_shared_counter_value);
    assign ev[c] = cap_ev[c] | cmp_ev[c];
    assign lo_acc[c] = acc & hit_lo[c];

    // routing of the enabled flag
    assign o_cpu_irq[c] = flag_q[c] & ie_q[c] & ~(HAS_DMA & sel_q[c]);
    assign o_dma_req[c] = flag_q[c] & dma_mode[c];

    // odd channels have no buffered select and read it as zero
    assign ctrl_rd[c] = dis[c] ? 8'h00 :
      {flag_q[c], ie_q[c], EVEN ? msb_q[c] : 1'b0, msa_q[c],
       els_q[c], tov_q[c], max_q[c]};
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge history

  // the first stage is read only by the second
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= i_channel_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel control fields

  // writes to a disabled odd channel are dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ie_q <= '0;
      msb_q <= '0;
      msa_q <= '0;
      tov_q <= '0;
      max_q <= '0;
      for (int c = 0; c < N_CH; c++) begin
        els_q[c] <= ELS_OFF;
      end
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (wr_ok && hit_ctrl[c] && !dis[c]) begin
          ie_q[c] <= i_pwdata[B_IE];
          msb_q[c] <= (c % 2 == 0) ? i_pwdata[B_MSB] : 1'b0;
          msa_q[c] <= i_pwdata[B_MSA];
          els_q[c] <= {i_pwdata[B_ELSH], i_pwdata[B_ELSL]};
          tov_q[c] <= i_pwdata[B_TOV];
          max_q[c] <= i_pwdata[B_MAX];
        end
      end
    end
  end

  // service request select, forced low without a dma module
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sel_q <= SEL_RST;
    end else if (wr_ok && i_paddr == OFF_SEL) begin
      sel_q <= HAS_DMA ? i_pwdata[N_CH-1:0] : SEL_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags

  // a new event always wins over any clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flag_q <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (ev[c]) begin
          flag_q[c] <= 1'b1;
        end else if (dma_mode[c] && lo_acc[c]) begin
          flag_q[c] <= 1'b0;
        end else if (wr_ok && hit_ctrl[c] && !i_pwdata[B_FLAG] &&
                     armed_q[c] && !dma_mode[c]) begin
          flag_q[c] <= 1'b0;
        end
      end
    end
  end

  // arming needs a read that returned the flag set; an event in
  // between disarms, so a stale write zero cannot drop it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      armed_q <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (ev[c] || (wr_ok && hit_ctrl[c]) || !flag_q[c]) begin
          armed_q[c] <= 1'b0;
        end else if (rd_ok && hit_ctrl[c] && prdata_q[B_FLAG]) begin
          armed_q[c] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel value latches

  // no reset on purpose; a software write wins over a capture
  always_ff @(posedge i_ref_clk) begin
    for (int c = 0; c < N_CH; c++) begin
      if (wr_ok && hit_hi[c]) begin
        val_q[c][15:8] <= i_pwdata[7:0];
      end else if (wr_ok && hit_lo[c]) begin
        val_q[c][7:0] <= i_pwdata[7:0];
      end else if (cap_ev[c]) begin
        val_q[c] <= i_shared_counter_value;
      end
    end
  end

  // capture lock between high and low reads, compare hold between
  // high and low writes, and the previous match state
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lock_q <= '0;
      cmpblk_q <= '0;
      match_q <= '0;
    end else begin
      for (int c = 0; c < N_CH; c++) begin
        if (rd_ok && hit_lo[c]) begin
          lock_q[c] <= 1'b0;
        end else if (rd_ok && hit_hi[c] && cap_mode[c]) begin
          lock_q[c] <= 1'b1;
        end
        if (wr_ok && hit_lo[c]) begin
          cmpblk_q[c] <= 1'b0;
        end else if (wr_ok && hit_hi[c] && cmp_mode[c]) begin
          cmpblk_q[c] <= 1'b1;
        end
        match_q[c] <= (val_q[c] == i_shared_counter_value);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data

  // unused bits and unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    for (int c = 0; c < N_CH; c++) begin
      if (hit_ctrl[c]) begin
        rdata_d[7:0] = ctrl_rd[c];
      end
      if (hit_hi[c]) begin
        rdata_d[7:0] = val_q[c][15:8];
      end
      if (hit_lo[c]) begin
        rdata_d[7:0] = val_q[c][7:0];
      end
    end
    if (i_paddr == OFF_SEL) begin
      rdata_d[N_CH-1:0] = sel_q;
    end
  end

  // staged in the setup cycle, held through the access cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prdata_q <= '0;
    end else if (setup && !i_pwrite) begin
      prdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  for (genvar c = 0; c < N_CH; c++) begin : g_chk
    AST_FLAG_SET: assert property (
      ev[c] |=> flag_q[c])
      else $error("event did not set channel flag");
    AST_IRQ: assert property (
      $rose(flag_q[c]) && ie_q[c] && !sel_q[c] |-> o_cpu_irq[c] &&
      !o_dma_req[c])
      else $error("enabled flag raised no cpu request");
    AST_SYNC: assert property (
      edge_det[c] |-> $past(i_channel_pin[c], 2) !=
      $past(i_channel_pin[c], 3))
      else $error("edge seen without a pin transition");
    AST_CAP_VALUE: assert property (
      cap_ev[c] && !wr_val[c] |=>
      val_q[c] == $past(i_shared_counter_value))
      else $error("captured value differs from counter");
    AST_LOCK: assert property (
      lock_q[c] && !wr_val[c] |=> $stable(val_q[c]))
      else $error("capture overwrote locked value");
    AST_RECAPTURE: assert property (
      flag_q[c] && cap_mode[c] && edge_det[c] && !lock_q[c] &&
      !rd_hi_pend[c] |-> cap_ev[c])
      else $error("edge dropped while flag set");
    AST_ARM: assert property (
      $fell(flag_q[c]) && !$past(dma_mode[c]) |-> $past(armed_q[c]) &&
      $past(wr_ok) && !$past(ev[c]))
      else $error("flag cleared without read then write zero");
    AST_DMA_CLR: assert property (
      dma_mode[c] && lo_acc[c] && !ev[c] |=> !flag_q[c])
      else $error("low byte access did not clear dma flag");
    AST_W1: assert property (
      wr_ok && hit_ctrl[c] && i_pwdata[B_FLAG] && !flag_q[c] &&
      !ev[c] |=> !flag_q[c])
      else $error("writing one set the flag");
    AST_DMA_ROUTE: assert property (
      flag_q[c] && dma_mode[c] |-> o_dma_req[c] && !o_cpu_irq[c])
      else $error("dma routed flag reached cpu");
    AST_DIS: assert property (
      dis[c] |-> ctrl_rd[c] == 8'h00 && !o_pin_connected[c] && !ev[c])
      else $error("disabled channel still active");
    AST_OFF: assert property (
      els_q[c] == ELS_OFF |-> !o_pin_connected[c] && !cap_ev[c])
      else $error("channel with edge select off still active");
    AST_RST: assert property (
      $fell(i_rst) |-> ctrl_rd[c] == CTRL_RST && !o_cpu_irq[c])
      else $error("control not cleared by reset");
    AST_CMP: assert property (
      cmp_mode[c] && !cmpblk_q[c] && !match_q[c] &&
      val_q[c] == i_shared_counter_value |=> flag_q[c])
      else $error("compare match did not set flag");
  end

  COV_CAP_WHILE_SET: cover property (flag_q[0] && cap_ev[0]);
  COV_DMA_CLEAR: cover property (dma_mode[0] && lo_acc[0] && flag_q[0]);
  COV_LOCK_BLOCK: cover property (lock_q[1] && edge_det[1]);
  COV_COMPARE: cover property (cmp_ev[2]);

endmodule

`default_nettype wire

// >>> tb/tcc_pin_source.sv
// pin sources and free-running shared count seen by the capture block
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_source (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_counter_halt,
  input wire logic [3:0] i_level,
  output logic [3:0] o_channel_pin,
  output logic [15:0] o_shared_counter_value
);
  // levels move only on clock edges and are held for many clocks,
  // so a pin is long settled before its edge choice is enabled
  always_ff @(posedge i_ref_clk) begin
    o_channel_pin <= i_level;
  end

  // free-running count; a halt also clears it, as software does
  // before a channel changes function
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_counter_halt) begin
      o_shared_counter_value <= 16'h0000;
    end else begin
      o_shared_counter_value <= o_shared_counter_value + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// >>> tb/tcc_capture_tb_top.sv
// self-checking bench for the timer channel capture/compare block
`timescale 1ns/1ps
`default_nettype none

module tcc_capture_tb_top;
  import tcc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, hlt;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rd;
  logic [N_CH-1:0] pins, lvl, irq, dma, conn, sel_m;
  logic [CW-1:0] cnt, v;
  logic [7:0] ctrl_m [N_CH];
  logic lock_m [N_CH];
  int n_errors, checks_done, seed, c0;
  int cap_m [N_CH];

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  tcc_capture #(.HAS_DMA(1'b1)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_channel_pin(pins),
    .i_shared_counter_value(cnt), .o_cpu_irq(irq), .o_dma_req(dma),
    .o_pin_connected(conn));

  tcc_pin_source src (
    .i_ref_clk(clk), .i_rst(rst), .i_counter_halt(hlt),
    .i_level(lvl), .o_channel_pin(pins),
    .o_shared_counter_value(cnt));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // expected request lines from the model: s=0 cpu, s=1 dma
  function automatic logic [3:0] req(input logic s);
    logic [3:0] r;
    for (int i = 0; i < N_CH; i++)
      r[i] = ctrl_m[i][7] & ctrl_m[i][6] & (sel_m[i] == s);
    return r;
  endfunction

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input int a, input int d);
    apb(1'b1, 8'(a), d);
  endtask

  task automatic rdc(input int a, input logic [31:0] e);
    apb(1'b0, 8'(a), 0);
    check(rd, e);
  endtask

  // move one pin; the model predicts flag and captured count
  task automatic set_pin(input int ch, input logic val);
    logic [1:0] els;
    logic hit;
    els = ctrl_m[ch][3:2];
    hit = !ctrl_m[ch][4] && ((val && !lvl[ch] && els[0]) ||
          (!val && lvl[ch] && els[1]));
    @(posedge clk);
    lvl[ch] <= val;
    #1 c0 = cnt;
    // a locked pair takes no capture and so raises no flag
    if (hit && !lock_m[ch]) begin
      ctrl_m[ch][7] = 1'b1;
      cap_m[ch] = c0 + 3;
    end
    repeat (6) @(posedge clk);
    check(irq, req(1'b0));
    check(dma, req(1'b1));
  endtask

  // high byte then low byte; one clock of latching slack is allowed
  task automatic chk_cap(input int ch);
    apb(1'b0, OFF_HI + 8'(4 * ch), 0);
    v[15:8] = rd[7:0];
    apb(1'b0, OFF_LO + 8'(4 * ch), 0);
    v[7:0] = rd[7:0];
    lock_m[ch] = 1'b0;
    check(v, (v == 16'(cap_m[ch] - 1)) ? v : 16'(cap_m[ch]));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    seed = 2;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lvl = '0;
    hlt = 1'b0;
    sel_m = '0;
    for (int i = 0; i < N_CH; i++) begin
      ctrl_m[i] = CTRL_RST;
      lock_m[i] = 1'b0;
    end
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // control and routing words come out of reset clear
    for (int i = 0; i < N_CH; i++) rdc(4 * i, CTRL_RST);
    rdc(OFF_SEL, SEL_RST);
    apb(1'b0, 8'h34, 0);
    check(err, 1'b1);
    // an idle value word is plain storage
    for (int i = 0; i < 3; i++) begin
      v = 16'($random(seed));
      cap_m[1] = v;
      wr(OFF_HI + 4, v[15:8]);
      wr(OFF_LO + 4, v[7:0]);
      chk_cap(1);
    end
    // flag ignores a written one; odd channels have no buffered bit
    wr(4, 'hef);
    rdc(4, 'h4f);
    check(conn, 4'h2);
    wr(0, 'hef);
    rdc(0, 'h6f);
    rdc(4, 0);
    check(conn, 4'h1);
    wr(0, 0);
    wr(4, 0);
    check(conn, 4'h0);
    // each channel its own edge choice, channel 0 off and the rest running side by side
    for (int ch = 0; ch < N_CH; ch++) begin
      ctrl_m[ch] = 8'h40 | 8'(ch << 2);
      wr(4 * ch, ctrl_m[ch]);
    end
    check(conn, 4'he);
    for (int ch = 0; ch < N_CH; ch++) begin
      set_pin(ch, 1'b1);
      rdc(4 * ch, ctrl_m[ch]);
      set_pin(ch, 1'b0);
      rdc(4 * ch, ctrl_m[ch]);
      if (ch != 0) chk_cap(ch);
    end
    // an event between arming read and clearing write wins
    set_pin(3, 1'b1);
    wr(12, 'h4c);
    rdc(12, ctrl_m[3]);
    wr(12, 'h4c);
    ctrl_m[3] = 8'h4c;
    rdc(12, ctrl_m[3]);
    // polled channel: high-byte read holds the pair until low read
    ctrl_m[3] = 8'h0c;
    wr(12, ctrl_m[3]);
    apb(1'b0, OFF_HI + 12, 0);
    lock_m[3] = 1'b1;
    set_pin(3, 1'b0);
    chk_cap(3);
    set_pin(3, 1'b1);
    chk_cap(3);
    rdc(12, 'h8c);
    // routed to dma, a low-byte access clears the flag
    wr(OFF_SEL, 1);
    sel_m = 4'h1;
    ctrl_m[0] = 8'h44;
    wr(0, ctrl_m[0]);
    set_pin(0, 1'b1);
    apb(1'b0, OFF_LO, 0);
    ctrl_m[0][7] = 1'b0;
    rdc(0, ctrl_m[0]);
    check(dma, 4'h0);
    // compare mode: a match with the count sets the flag
    rdc(8, ctrl_m[2]);
    // count stopped and cleared while the channel changes role
    @(posedge clk) hlt <= 1'b1;
    ctrl_m[2] = 8'h14;
    wr(8, ctrl_m[2]);
    v = cnt + 16'h0028;
    wr(OFF_HI + 8, v[15:8]);
    wr(OFF_LO + 8, v[7:0]);
    @(posedge clk) hlt <= 1'b0;
    rdc(8, ctrl_m[2]);
    repeat (40) @(posedge clk);
    rdc(8, 8'h94);
    give_verdict();
  end
endmodule

`default_nettype wire
